/* logic/wdt_pkg.sv */
// constants used by the board watchdog timer module; wdt_counter takes its width as a parameter
package wdt_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  // timeout figures in milliseconds
  localparam int unsigned SHORT_MS      = 30;
  localparam int unsigned MEDIUM_MS     = 10_000;
  localparam int unsigned LONG_MS       = 60_000;
  // timeout figures in clock cycles
  localparam int unsigned SHORT_CYC     = SHORT_MS * CYC_PER_MS;
  localparam int unsigned MEDIUM_CYC    = MEDIUM_MS * CYC_PER_MS;
  localparam int unsigned LONG_CYC      = LONG_MS * CYC_PER_MS;
  localparam int          CNT_W         = 30;
  // i/o space
  localparam logic [15:0] GPIO_BASE     = 16'h0500;
  localparam logic [15:0] LEVEL_OFS     = 16'h000C;
  localparam logic [15:0] LEVEL_ADDR    = GPIO_BASE + LEVEL_OFS;
  localparam logic [15:0] UPPER_ADDR    = 16'h050E;
  // field positions within gpio_pin_level
  localparam int          KICK_BIT      = 19;
  localparam int          SEL_LOW_BIT   = 20;
  localparam int          SEL_HIGH_BIT  = 23;
  localparam logic [31:0] LEVEL_RESET   = 32'h0010_0000;
  // select encodings, high bit first
  localparam logic [1:0]  SEL_SHORT     = 2'h0;
  localparam logic [1:0]  SEL_OFF       = 2'h1;
  localparam logic [1:0]  SEL_MEDIUM    = 2'h2;
  localparam logic [1:0]  SEL_LONG      = 2'h3;
endpackage

/* logic/wdt_counter.sv */
// timeout counter with a sticky expiry flag
`timescale 1ns/1ps
module wdt_counter #(
  parameter int CNT_W = 30
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // control
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] limit,
  // status
  output logic      [CNT_W-1:0] count,
  output logic                  expired
);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (clear || expired) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // once set only a reset ends it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      expired <= 1'b0;
    end else if (!clear && count == limit - 1'b1) begin
      expired <= 1'b1;
    end
  end

endmodule

/* logic/board_watchdog_timer.sv */
// board watchdog reached through the gpio pin level register
`timescale 1ns/1ps
module board_watchdog_timer #(
  parameter int unsigned SHORT_CYC  = wdt_pkg::SHORT_CYC,
  parameter int unsigned MEDIUM_CYC = wdt_pkg::MEDIUM_CYC,
  parameter int unsigned LONG_CYC   = wdt_pkg::LONG_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // i/o space access
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWide,
  input  wire logic        ioWrite,
  input  wire logic        ioRead,
  input  wire logic [31:0] ioWrData,
  output logic      [31:0] ioRdData,
  // board
  output logic             powerGood
);

  localparam int CW = wdt_pkg::CNT_W;

  // ***************************************************************
  // timeout decode
  // ***************************************************************
  function automatic logic [CW-1:0] limitFor(input logic [1:0] sel);
    logic [CW-1:0] lim;
    lim = CW'(LONG_CYC);
    unique case (sel)
      wdt_pkg::SEL_SHORT:  lim = CW'(SHORT_CYC);
      wdt_pkg::SEL_OFF:    lim = CW'(LONG_CYC);
      wdt_pkg::SEL_MEDIUM: lim = CW'(MEDIUM_CYC);
      wdt_pkg::SEL_LONG:   lim = CW'(LONG_CYC);
    endcase
    return lim;
  endfunction

  // ***************************************************************
  // level register
  // ***************************************************************
  logic [31:0] levelQ;
  logic        dwordHit;
  logic        byteHit;
  logic [1:0]  lane;

  assign dwordHit = ioWide && ioAddr == wdt_pkg::LEVEL_ADDR;
  assign byteHit  = !ioWide && ioAddr[15:2] == wdt_pkg::LEVEL_ADDR[15:2];
  assign lane     = ioAddr[1:0];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      levelQ <= wdt_pkg::LEVEL_RESET;
    end else if (ioWrite && dwordHit) begin
      levelQ <= ioWrData;
    end else if (ioWrite && byteHit) begin
      levelQ[lane*8 +: 8] <= ioWrData[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ioRdData <= '0;
    end else if (ioRead && dwordHit) begin
      ioRdData <= levelQ;
    end else if (ioRead && byteHit) begin
      ioRdData <= {24'h00_0000, levelQ[lane*8 +: 8]};
    end else if (ioRead) begin
      ioRdData <= '0;
    end
  end

  // ***************************************************************
  // kick and select tracking
  // ***************************************************************
  logic       kick;
  logic [1:0] sel;
  logic       kickPrevQ;
  logic [1:0] selPrevQ;
  logic       enabled;
  logic       restart;

  assign kick    = levelQ[wdt_pkg::KICK_BIT];
  assign sel     = {levelQ[wdt_pkg::SEL_HIGH_BIT],
                    levelQ[wdt_pkg::SEL_LOW_BIT]};
  assign enabled = sel != wdt_pkg::SEL_OFF;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      kickPrevQ <= wdt_pkg::LEVEL_RESET[wdt_pkg::KICK_BIT];
      selPrevQ  <= wdt_pkg::SEL_OFF;
    end else begin
      kickPrevQ <= kick;
      selPrevQ  <= sel;
    end
  end

  // either edge of the kick restarts the period
  assign restart = (kick ^ kickPrevQ) || sel != selPrevQ
                   || !enabled;

  // ***************************************************************
  // timeout and power good
  // ***************************************************************
  logic [CW-1:0] count;
  logic          expired;

  wdt_counter #(
    .CNT_W   (CW)
  ) timer (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (restart),
    .limit   (limitFor(sel)),
    .count   (count),
    .expired (expired)
  );

  // the only reset path out is power good
  assign powerGood = !expired;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence lastCycle;
    enabled && !restart && count == limitFor(sel) - 1'b1;
  endsequence

  sequence kickEdge;
    kick != kickPrevQ;
  endsequence

  sequence selChange;
    sel != selPrevQ;
  endsequence

  AST_EXPIRE: assert property (
    @(posedge clock) disable iff (!rst_b)
    lastCycle |=> !powerGood)
    else $error("power good not dropped at timeout");

  AST_NO_EARLY: assert property (
    @(posedge clock) disable iff (!rst_b)
    powerGood && count < limitFor(sel) - 1'b1 |=> powerGood)
    else $error("power good dropped before timeout");

  AST_OFF_HOLDS: assert property (
    @(posedge clock) disable iff (!rst_b)
    sel == wdt_pkg::SEL_OFF && powerGood |=> powerGood && count == '0)
    else $error("disabled watchdog moved");

  AST_SHORT_LIMIT: assert property (
    @(posedge clock) disable iff (!rst_b)
    sel == wdt_pkg::SEL_SHORT && powerGood && !restart
    |-> count < CW'(SHORT_CYC))
    else $error("short select overran its period");

  AST_LATCHED: assert property (
    @(posedge clock) disable iff (!rst_b)
    !powerGood |=> !powerGood [*4])
    else $error("power good returned without reset");

  AST_DWORD_WR: assert property (
    @(posedge clock) disable iff (!rst_b)
    ioWrite && dwordHit |=> levelQ == $past(ioWrData))
    else $error("dword write not stored");

  AST_BYTE_WR: assert property (
    @(posedge clock) disable iff (!rst_b)
    ioWrite && !ioWide && ioAddr == wdt_pkg::UPPER_ADDR
    |=> levelQ[23:16] == $past(ioWrData[7:0]))
    else $error("upper byte write not stored");

  AST_KICK_CLEAR: assert property (
    @(posedge clock) disable iff (!rst_b)
    kickEdge ##0 powerGood |=> count == '0 ##1 count == CW'(1) || restart)
    else $error("kick did not restart count");

  AST_MEDIUM_LIMIT: assert property (
    @(posedge clock) disable iff (!rst_b)
    sel == wdt_pkg::SEL_MEDIUM && powerGood && !restart
    |-> count < CW'(MEDIUM_CYC))
    else $error("medium select overran its period");

  AST_LONG_LIMIT: assert property (
    @(posedge clock) disable iff (!rst_b)
    sel == wdt_pkg::SEL_LONG && powerGood && !restart
    |-> count < CW'(LONG_CYC))
    else $error("long select overran its period");

  AST_SEL_RESTART: assert property (
    @(posedge clock) disable iff (!rst_b)
    selChange |=> count == '0)
    else $error("select change did not restart count");

  AST_RESTART_SAFE: assert property (
    @(posedge clock) disable iff (!rst_b)
    restart && powerGood |=> powerGood)
    else $error("restart cycle dropped power good");

  AST_RD_DWORD: assert property (
    @(posedge clock) disable iff (!rst_b)
    ioRead && dwordHit |=> ioRdData == $past(levelQ))
    else $error("dword read returned wrong data");

  AST_RD_BYTE: assert property (
    @(posedge clock) disable iff (!rst_b)
    ioRead && !ioWide && ioAddr == wdt_pkg::UPPER_ADDR
    |=> ioRdData == {24'h00_0000, $past(levelQ[23:16])})
    else $error("upper byte read returned wrong data");

  AST_RD_MISS: assert property (
    @(posedge clock) disable iff (!rst_b)
    ioRead && !dwordHit && !byteHit |=> ioRdData == '0)
    else $error("read outside the register not zero");

  AST_LEVEL_HOLD: assert property (
    @(posedge clock) disable iff (!rst_b)
    !ioWrite |=> levelQ == $past(levelQ))
    else $error("level register moved without a write");

endmodule

/* testbench/board_watchdog_timer_tb_top.sv */
// self-checking bench for the board watchdog
`timescale 1ns/1ps
module board_watchdog_timer_tb_top;
  localparam int unsigned SHORT  = 20;
  localparam int unsigned MEDIUM = 40;
  localparam int unsigned LONG   = 60;
  logic        clock;
  logic        rst_b;
  logic [15:0] ioAddr;
  logic        ioWide;
  logic        ioWrite;
  logic        ioRead;
  logic [31:0] ioWrData;
  logic [31:0] ioRdData;
  logic        powerGood;
  logic [31:0] lvl;
  logic        rdSeen = 1'b0;
  logic [31:0] expQ[$];
  int          n_fail = 0;
  int          checked = 0;

  board_watchdog_timer #(.SHORT_CYC(SHORT), .MEDIUM_CYC(MEDIUM),
    .LONG_CYC(LONG)) u_board_watchdog_timer (.clock(clock), .rst_b(rst_b),
    .ioAddr(ioAddr), .ioWide(ioWide), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .powerGood(powerGood));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ***************************************
  // checking
  // ***************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // read data shows one cycle after the read edge
  always @(posedge clock) begin
    if (rdSeen)
      check(ioRdData, expQ.pop_front());
    rdSeen <= ioRead && rst_b;
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    give_verdict;
  end

  // ***************************************
  // drivers
  // ***************************************
  task automatic wr(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    ioAddr   <= a;
    ioWide   <= w;
    ioWrData <= d;
    ioWrite  <= 1'b1;
    @(posedge clock);
    ioWrite  <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic w, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge clock);
    ioAddr <= a;
    ioWide <= w;
    ioRead <= 1'b1;
    @(posedge clock);
    ioRead <= 1'b0;
  endtask

  task automatic hold(input int n, input logic pg);
    repeat (n) @(posedge clock);
    #1;
    check({31'h0, powerGood}, {31'h0, pg});
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    lvl = 32'h0010_0000;
  endtask

  // select a period, kick just in time, then let it expire
  task automatic run_sel(input logic [1:0] sel);
    int          lim;
    logic [7:0]  b;
    lim = (sel == 2'h0) ? SHORT : (sel == 2'h2) ? MEDIUM : LONG;
    do_reset;
    b = 8'($urandom & 32'h67) | {sel[1], 2'h0, sel[0], 4'h0};
    wr(16'h050E, 1'b0, 32'h0000_0018);
    lvl[23:16] = b;
    wr(16'h050E, 1'b0, {24'h0, b});
    hold(lim - 3, 1'b1);
    lvl = ($urandom & 32'hFF67_FFFF) | (lvl & 32'h0090_0000)
        | (~lvl & 32'h0008_0000);
    wr(16'h050C, 1'b1, lvl);
    hold(lim, 1'b1);
    hold(1, 1'b0);
    rd(16'h050C, 1'b1, lvl);
    // let the read result be compared before the next reset
    @(posedge clock);
    $display("test select %0d done", sel);
  endtask

  // ***************************************
  // sequence
  // ***************************************
  initial begin
    void'($urandom(65147));
    rst_b    = 1'b0;
    ioAddr   = 16'h0000;
    ioWide   = 1'b0;
    ioWrite  = 1'b0;
    ioRead   = 1'b0;
    ioWrData = 32'h0;
    do_reset;
    rd(16'h050C, 1'b1, 32'h0010_0000);
    rd(16'h050E, 1'b0, 32'h0000_0010);
    rd(16'h050E, 1'b1, 32'h0);
    wr(16'h0600, 1'b1, 32'h0008_0000);
    rd(16'h0600, 1'b1, 32'h0);
    hold(100, 1'b1);
    $display("test reset and map done");
    for (int s = 0; s < 4; s++)
      if (s != 1)
        run_sel(s[1:0]);
    repeat (3) @(posedge clock);
    give_verdict;
  end
endmodule
